// *** verification/crf_clock_ready_irq_tb.sv ***
`timescale 1ns/1ps
module crf_clock_ready_irq_tb;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                    pclk;
  logic                    presetn;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [11:0]             paddr;
  logic [31:0]             pwdata;
  logic [3:0]              pstrb;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  crf_pkg::crf_osc_ready_t ev;
  logic                    clock_irq;
  int                      mismatches;
  int                      total_checks;
  logic [11:0]             a;

  assign a = crf_pkg::CRF_INT_OFFSET;

  crf_clock_ready_irq #(.ADDR_W(12)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_ready_i(ev), .clock_irq(clock_irq));

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  // The whole run needs well under two thousand cycles.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    #(25 * 20000);
    mismatches++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // The request stands until ready is seen high at a rising edge, and
  // the answer is taken at that same edge. Only the watchdog ends a wait.
  task automatic apb(input logic wr_en, input logic [11:0] ad,
                     input logic [31:0] wd, input logic [3:0] st,
                     output logic [31:0] rd_d, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= ad;
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_d = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] ad, input logic [31:0] d,
                    input logic [3:0] s);
    logic [31:0] r;
    logic        e;
    apb(1'b1, ad, d, s, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] ad, input logic [31:0] exp,
                    input logic exp_err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, ad, 32'h00000000, 4'h0, r, e);
    check(r, exp);
    check({31'h0, e}, {31'h0, exp_err});
  endtask : rd

  task automatic irq_is(input logic exp);
    check({31'h0, clock_irq}, {31'h0, exp});
  endtask : irq_is

  // A level must stay put for at least one cycle to be seen once.
  task automatic drive_ev(input int i, input logic v);
    @(posedge pclk);
    ev[i] <= v;
    repeat (4) @(posedge pclk);
  endtask : drive_ev

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_enables();
    rd(a, 32'h00000000, 1'b0);
    irq_is(1'b0);
    wr(a, 32'hFFFFFFFF, 4'hF);
    rd(a, 32'h00003F00, 1'b0);
    wr(a, 32'h00001500, 4'h2);
    rd(a, 32'h00001500, 1'b0);
    wr(a, 32'hFFFFFFFF, 4'h1);
    rd(a, 32'h00001500, 1'b0);
    $display("test enables done");
  endtask : test_enables

  task automatic test_events();
    wr(a, 32'h00003F00, 4'h2);
    for (int i = 0; i < 6; i++) begin
      drive_ev(i, 1'b1);
      rd(a, 32'h3F00 | (32'h1 << i), 1'b0);
      irq_is(1'b1);
      wr(a, 32'h00003F00, 4'h6);
      rd(a, 32'h00003F00 | (32'h1 << i), 1'b0);
      wr(a, (32'h1 << (16 + i)) | 32'h00003F00, 4'h6);
      rd(a, 32'h00003F00, 1'b0);
      irq_is(1'b0);
      drive_ev(i, 1'b0);
    end
    $display("test events done");
  endtask : test_events

  // An event seen while disabled is lost, even if enabled later.
  task automatic test_disabled();
    wr(a, 32'h00000000, 4'h2);
    drive_ev(0, 1'b1);
    rd(a, 32'h00000000, 1'b0);
    wr(a, 32'h00000100, 4'h2);
    repeat (4) @(posedge pclk);
    rd(a, 32'h00000100, 1'b0);
    irq_is(1'b0);
    drive_ev(0, 1'b0);
    $display("test disabled done");
  endtask : test_disabled

  task automatic test_security();
    drive_ev(6, 1'b1);
    rd(a, 32'h00000180, 1'b0);
    irq_is(1'b1);
    wr(a, 32'h00000000, 4'h4);
    rd(a, 32'h00000180, 1'b0);
    wr(a, 32'h003F0000, 4'h4);
    rd(a, 32'h00000180, 1'b0);
    wr(a, 32'h00BF0000, 4'h4);
    rd(a, 32'h00000100, 1'b0);
    irq_is(1'b0);
    drive_ev(6, 1'b0);
    $display("test security done");
  endtask : test_security

  task automatic test_unmapped();
    rd(12'h00C, 32'h00000000, 1'b1);
    wr(12'h00C, 32'hFFFFFFFF, 4'hF);
    rd(a, 32'h00000100, 1'b0);
    $display("test unmapped done");
  endtask : test_unmapped

  // A reset in mid-run clears flags, enables and the request at once.
  task automatic test_reset();
    wr(a, 32'h00000100, 4'h2);
    drive_ev(0, 1'b1);
    irq_is(1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    irq_is(1'b0);
    presetn <= 1'b1;
    rd(a, 32'h00000000, 1'b0);
    irq_is(1'b0);
    drive_ev(0, 1'b0);
    $display("test reset done");
  endtask : test_reset

  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    mismatches = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    ev = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    test_enables();
    test_events();
    test_disabled();
    test_security();
    test_unmapped();
    test_reset();
    complete_run();
  end

endmodule : crf_clock_ready_irq_tb

// *** verilog/crf_clock_ready_irq.sv ***
`timescale 1ns/1ps
// How it works
// - Low-speed internal ready edge sets bit 0 if enabled; clear drops it.
// - Low-speed external ready edge sets bit 1 if enabled; clear drops it.
// - High-speed internal ready edge sets bit 2 if enabled; clear drops it.
// - High-speed external ready edge sets bit 3 if enabled; clear drops it.
// - Loop lock ready edge sets bit 4 if enabled; clear drops it.
// - Fourteen MHz ready edge sets bit 5 if enabled; clear drops it.
// - External oscillator failure always sets sticky flag bit 7.
// - Writing one to bit 23 clears the failure flag; zero does nothing.
// - Bit 8 is a read-write enable for the low-speed internal event.
// - Bit 9 is a read-write enable for the low-speed external event.
// - Bit 10 is a read-write enable for the high-speed internal event.
// - Bit 11 is a read-write enable for the high-speed external event.
// - Bit 12 is a read-write enable for the loop lock event.
// - Bit 13 is a read-write enable for the fourteen MHz event.
// - Bits 16 to 21 clear the ready flags in source order when one.
// - Word, half word and byte access, always with zero wait cycles.

module crf_clock_ready_irq #(
  parameter int ADDR_W = 12
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire crf_pkg::crf_osc_ready_t osc_ready_i,
  output logic                      clock_irq
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------

  // True when the word address hits the control register.
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = ADDR_W'(crf_pkg::CRF_INT_OFFSET);
    return a[ADDR_W-1:2] == off[ADDR_W-1:2];
  endfunction : addr_hit

  // Expands the byte strobes into a bit mask.
  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    return m;
  endfunction : lane_mask

  // Builds the read view; clears and reserved bits stay zero.
  function automatic logic [31:0] read_word(
    input crf_pkg::crf_state_t s
  );
    logic [31:0] w;
    w = crf_pkg::CRF_INT_RESET;
    w[crf_pkg::CRF_FLAG_LSB +: crf_pkg::CRF_NSRC] = s.ready_flag;
    w[crf_pkg::CRF_CSS_FLAG] = s.clock_security_fail_flag;
    w[crf_pkg::CRF_EN_LSB +: crf_pkg::CRF_NSRC] = s.ready_irq_en;
    return w;
  endfunction : read_word

  // ---------------------------------------------------------------
  // State and next state
  // ---------------------------------------------------------------

  crf_pkg::crf_state_t state_ff;
  crf_pkg::crf_state_t nxt_state;

  logic        setup_ph;
  logic        access_ph;
  logic        wr_take;
  logic [31:0] wr_bits;
  logic [6:0]  ev_rise;
  logic [5:0]  rdy_set;
  logic [5:0]  rdy_clr;
  logic        css_clr;
  logic [5:0]  en_mask;
  logic [31:0] strb_bits;

  // Bus phases; the access phase always ends in one cycle.
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_take   = access_ph && pwrite && addr_hit(paddr);

  // Byte strobes widened to one bit per data bit.
  assign strb_bits = lane_mask(pstrb);

  // Only strobed lanes of the write data count.
  assign wr_bits = wr_take ? (pwdata & strb_bits)
                           : 32'h00000000;

  // Events are rising edges of the synchronised lines, so a
  // source that stays ready does not refill a cleared flag.
  // Limitation: a line that drops and returns within one cycle
  // may be missed. The sources are slow levels, so a one-cycle
  // minimum width costs nothing. An edge seen while its enable
  // is zero is dropped, not held, so enabling a source that is
  // already up gives no flag for it.
  assign ev_rise = state_ff.sync2 & ~state_ff.prev;

  // Ready events pass only while their enable is one.
  assign rdy_set = ev_rise[crf_pkg::CRF_NSRC-1:0]
                 & state_ff.ready_irq_en;

  // Clear strobes, one per ready flag in source order.
  assign rdy_clr = wr_bits[crf_pkg::CRF_CLR_LSB +:
                           crf_pkg::CRF_NSRC];
  assign css_clr = wr_bits[crf_pkg::CRF_CSS_CLR];

  // Enable bits touched by this write.
  assign en_mask = wr_take ? strb_bits[crf_pkg::CRF_EN_LSB +:
                                       crf_pkg::CRF_NSRC]
                           : 6'h00;

  // Next-state logic for the whole block.
  always_comb begin
    nxt_state = state_ff;

    // Two flops settle each asynchronous line before use.
    nxt_state.sync1 = osc_ready_i;
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.prev  = state_ff.sync2;

    // Set wins over clear so no event is lost.
    nxt_state.ready_flag = (state_ff.ready_flag & ~rdy_clr)
                         | rdy_set;

    // The failure flag needs no enable and is sticky.
    nxt_state.clock_security_fail_flag =
      (state_ff.clock_security_fail_flag && !css_clr)
      || ev_rise[crf_pkg::CRF_CSS_EV];

    // Enables update only in strobed lanes.
    nxt_state.ready_irq_en =
      (state_ff.ready_irq_en & ~en_mask)
      | (pwdata[crf_pkg::CRF_EN_LSB +: crf_pkg::CRF_NSRC]
         & en_mask);

    // No wait states: ready stands high from the first edge.
    nxt_state.pready = 1'b1;

    // Read data and error are prepared in the setup cycle so
    // that they come straight from flops in the access cycle.
    if (setup_ph) begin
      nxt_state.prdata  = (addr_hit(paddr) && !pwrite)
                        ? read_word(state_ff)
                        : 32'h00000000;
      nxt_state.pslverr = !addr_hit(paddr);
    end else if (!psel) begin
      nxt_state.prdata  = 32'h00000000;
      nxt_state.pslverr = 1'b0;
    end

    // Request follows the stored flags in the same edge.
    nxt_state.irq = (|nxt_state.ready_flag)
                  || nxt_state.clock_security_fail_flag;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------

  // All state is cleared by the system reset. Ready also starts
  // low, so no transfer can complete while the block is still
  // coming out of reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff.sync1      <= crf_pkg::CRF_EV_RESET;
      state_ff.sync2      <= crf_pkg::CRF_EV_RESET;
      state_ff.prev       <= crf_pkg::CRF_EV_RESET;
      state_ff.ready_flag <= crf_pkg::CRF_FLAG_RESET;
      state_ff.clock_security_fail_flag <= 1'b0;
      state_ff.ready_irq_en <= crf_pkg::CRF_EN_RESET;
      state_ff.prdata     <= crf_pkg::CRF_INT_RESET;
      state_ff.pready     <= 1'b0;
      state_ff.pslverr    <= 1'b0;
      state_ff.irq        <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs are taken directly from the state flops.
  assign prdata    = state_ff.prdata;
  assign pready    = state_ff.pready;
  assign pslverr   = state_ff.pslverr;
  assign clock_irq = state_ff.irq;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Bus inputs appear only as triggers, except pwdata in en_write_a; every
  // other check looks at the block's own state or outputs. The failure path
  // is a named sequence; osc_path_a spells out the sync chain's cycles itself.

  // A bus transfer split into its two phases.
  sequence setup_s;
    psel && !penable;
  endsequence

  sequence access_s;
    psel && penable;
  endsequence

  // A read of the control word.
  sequence rd_s;
    setup_s and (!pwrite && addr_hit(paddr));
  endsequence

  // Setup cycle of a transfer that hits the control word.
  sequence hit_s;
    setup_s and addr_hit(paddr);
  endsequence

  // The failure line rises and crosses both sync flops; the flag
  // follows at the next edge.
  sequence fail_rise_s;
    $rose(osc_ready_i.highspeed_ext_fail) ##2 1'b1;
  endsequence

  // Every enabled ready edge lands in its flag.
  ready_set_a : assert property (
    (|rdy_set) |=> ((state_ff.ready_flag & $past(rdy_set))
                    == $past(rdy_set))
  ) else $error("enabled ready event did not set flag");

  // Disabled sources never raise a flag.
  ready_gate_a : assert property (
    1'b1 |=> ((state_ff.ready_flag
               & ~$past(state_ff.ready_flag)
               & ~$past(state_ff.ready_irq_en)) == 6'h00)
  ) else $error("ready flag rose while disabled");

  // A line that goes ready reaches its flag three edges later.
  osc_path_a : assert property (
    ($rose(osc_ready_i.loop_lock) && state_ff.ready_irq_en[4])
    ##1 (state_ff.ready_irq_en[4] && !rdy_clr[4])
    ##1 (state_ff.ready_irq_en[4] && !rdy_clr[4])
    |=> state_ff.ready_flag[4]
  ) else $error("lock event did not reach its flag");

  // The failure flag sets without any enable.
  css_set_a : assert property (
    ev_rise[crf_pkg::CRF_CSS_EV] |=>
      state_ff.clock_security_fail_flag
  ) else $error("failure event lost");

  // The failure flag holds until software clears it.
  css_hold_a : assert property (
    (state_ff.clock_security_fail_flag && !css_clr) |=>
      state_ff.clock_security_fail_flag
  ) else $error("failure flag dropped without clear");

  // Writing one to the security clear bit drops the flag.
  css_clear_a : assert property (
    (css_clr && !ev_rise[crf_pkg::CRF_CSS_EV]) |=>
      !state_ff.clock_security_fail_flag
  ) else $error("failure flag not cleared");

  // Clear strobes drop exactly the matching ready flags.
  ready_clear_a : assert property (
    (|rdy_clr) |=> ((state_ff.ready_flag & $past(rdy_clr)
                     & ~$past(rdy_set)) == 6'h00)
  ) else $error("ready flag survived its clear");

  // Ready flags without a clear are sticky.
  ready_hold_a : assert property (
    1'b1 |=> ((($past(state_ff.ready_flag) & ~$past(rdy_clr))
               & ~state_ff.ready_flag) == 6'h00)
  ) else $error("ready flag lost without clear");

  // A strobed write to lane one loads the enables.
  en_write_a : assert property (
    (wr_take && pstrb[1]) |=>
      (state_ff.ready_irq_en == $past(pwdata[13:8]))
  ) else $error("enable bits not written");

  // Writes that skip lane one leave the enables alone.
  en_keep_a : assert property (
    !(wr_take && pstrb[1]) |=> $stable(state_ff.ready_irq_en)
  ) else $error("enable bits changed without write");

  // Every access phase completes at once.
  zero_wait_a : assert property (
    setup_s ##1 access_s |-> pready
  ) else $error("access phase stalled");

  // A read returns the state seen in the setup cycle.
  read_data_a : assert property (
    rd_s ##1 access_s |-> (prdata == $past(read_word(state_ff)))
  ) else $error("read data wrong");

  // Reserved and clear positions always read zero.
  resvd_zero_a : assert property (
    access_s |-> ((prdata & 32'hFFFFC040) == 32'h00000000)
  ) else $error("reserved bits read non-zero");

  // Unmapped addresses answer with an error.
  unmapped_a : assert property (
    (setup_s and !addr_hit(paddr)) ##1 access_s |-> pslverr
  ) else $error("unmapped access not flagged");

  // The request tracks the flags.
  irq_level_a : assert property (
    clock_irq == ((|state_ff.ready_flag)
                  || state_ff.clock_security_fail_flag)
  ) else $error("interrupt request out of step");

  // Clearing the last flag drops the request next edge.
  irq_drop_a : assert property (
    (wr_take && (rdy_clr == 6'h3F) && css_clr
     && (ev_rise == 7'h00)) |=> !clock_irq
  ) else $error("request stayed after full clear");

  // A failure line edge reaches its flag three edges later.
  css_path_a : assert property (
    fail_rise_s |=> state_ff.clock_security_fail_flag
  ) else $error("failure line did not reach its flag");

  // Any event that sets a flag also raises the request.
  irq_set_a : assert property (
    ((|rdy_set) || ev_rise[crf_pkg::CRF_CSS_EV]) |=> clock_irq
  ) else $error("request missing after event");

  // With nothing left set and no new event the request drops.
  irq_low_a : assert property (
    (((state_ff.ready_flag & ~rdy_clr) == 6'h00) && !(|rdy_set)
     && (!state_ff.clock_security_fail_flag || css_clr)
     && !ev_rise[crf_pkg::CRF_CSS_EV]) |=> !clock_irq
  ) else $error("request stayed with no flag set");

  // Once up, ready stays high until the next reset.
  pready_on_a : assert property (
    pready |=> pready
  ) else $error("ready fell outside reset");

  // A mapped access completes without an error.
  mapped_ok_a : assert property (
    hit_s ##1 access_s |-> !pslverr
  ) else $error("mapped access flagged as error");

  // An unmapped read or write returns all zeros.
  unmapped_zero_a : assert property (
    (setup_s and !addr_hit(paddr)) ##1 access_s |->
      (prdata == 32'h00000000)
  ) else $error("unmapped access returned data");

  // Between transfers read data and error rest at zero.
  bus_idle_a : assert property (
    !psel |=> ((prdata == 32'h00000000) && !pslverr)
  ) else $error("read data or error left standing");

  // Clears come only from lane two of a write.
  clr_lane_a : assert property (
    !(wr_take && pstrb[2]) |-> ((rdy_clr == 6'h00) && !css_clr)
  ) else $error("clear taken from an unstrobed lane");

  // A read with no event leaves flags and enables as they were.
  read_quiet_a : assert property (
    (access_s and (!pwrite && (ev_rise == 7'h00))) |=>
      ($stable(state_ff.ready_flag) && $stable(state_ff.ready_irq_en)
       && $stable(state_ff.clock_security_fail_flag))
  ) else $error("read disturbed the register");

endmodule : crf_clock_ready_irq

// *** verilog/crf_pkg.sv ***
package crf_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------

  // Byte offset of the clock interrupt control word.
  localparam logic [11:0] CRF_INT_OFFSET = 12'h008;
  // Value of the whole word after reset.
  localparam logic [31:0] CRF_INT_RESET  = 32'h00000000;

  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------

  // Number of oscillator sources with a ready event.
  localparam int CRF_NSRC     = 6;
  // Ready events plus the clock security failure event.
  localparam int CRF_NEV      = 7;
  // Lowest bit of the ready flags, one per source.
  localparam int CRF_FLAG_LSB = 0;
  // Position of the clock security failure flag.
  localparam int CRF_CSS_FLAG = 7;
  // Lowest bit of the ready interrupt enables.
  localparam int CRF_EN_LSB   = 8;
  // Lowest bit of the write-only ready clears.
  localparam int CRF_CLR_LSB  = 16;
  // Position of the clock security clear bit.
  localparam int CRF_CSS_CLR  = 23;
  // Index of the security failure line in the event vector.
  localparam int CRF_CSS_EV   = 6;

  // Reset values of the stored fields.
  localparam logic [5:0] CRF_FLAG_RESET = 6'h00;
  localparam logic [5:0] CRF_EN_RESET   = 6'h00;
  localparam logic [6:0] CRF_EV_RESET   = 7'h00;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------

  // Raw ready and failure lines, lowest source in bit 0.
  typedef struct packed {
    logic highspeed_ext_fail;
    logic internal_fourteen_mhz_osc;
    logic loop_lock;
    logic highspeed_external_osc;
    logic highspeed_internal_osc;
    logic lowspeed_external_osc;
    logic lowspeed_internal_osc;
  } crf_osc_ready_t;

  // Whole state of the block, registered as one word.
  typedef struct packed {
    logic [6:0]  sync1;
    logic [6:0]  sync2;
    logic [6:0]  prev;
    logic [5:0]  ready_flag;
    logic        clock_security_fail_flag;
    logic [5:0]  ready_irq_en;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
  } crf_state_t;

endpackage : crf_pkg
